// ---- rortd_checker.sv ----
// checker: port-level assertions of the ring offset / trip block
`timescale 1ns/100ps
module rortd_checker
  import rortd_pkg::*;
#(
  parameter logic [15:0] TICK_CYCLES = 16'h0008
) (
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [15:0] ring_drive_o,
  input wire logic        ringing_active_o,
  input wire logic [5:0]  ringing_common_mode_o,
  input wire logic        current_boost_o,
  input wire logic        irq_o
);
  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // zero wait states, error only inside an access phase
  property p_ready; pready_o == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err; pslverr_o |-> psel_i && penable_i; endproperty
  a_err: assert property (p_err) else $error("slave error outside access");
  // read data moves only after a setup edge
  property p_rdata; $past(!(psel_i && !penable_i)) |-> $stable(prdata_o); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
  // no drive two cycles after the on phase ends
  property p_quiet; !ringing_active_o && $past(!ringing_active_o) |-> ring_drive_o == 16'h0000; endproperty
  a_quiet: assert property (p_quiet) else $error("drive outside ring");
  // common mode latched for the whole on phase
  property p_cm;
    ringing_active_o && $past(ringing_active_o) && $past(ringing_active_o, 2) |-> $stable(ringing_common_mode_o);
  endproperty
  a_cm: assert property (p_cm) else $error("common mode moved");
  // boost only once ringing has stopped, and never a glitch
  property p_boost; $rose(current_boost_o) |-> !ringing_active_o; endproperty
  a_boost: assert property (p_boost) else $error("boost while ringing");
  property p_blen; $rose(current_boost_o) |-> current_boost_o [*8]; endproperty
  a_blen: assert property (p_blen) else $error("boost too short");
  // interrupt drops only through a register write
  property p_irq; $fell(irq_o) |-> $past(psel_i && penable_i && pwrite_i); endproperty
  a_irq: assert property (p_irq) else $error("irq dropped alone");
  c_irq: cover property ($rose(irq_o));
  c_ring: cover property ($rose(ringing_active_o));
  c_boost: cover property ($rose(current_boost_o));
  c_err: cover property (pslverr_o);
endmodule : rortd_checker

bind rortd_top rortd_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .ring_drive_o(ring_drive_o), .ringing_active_o(ringing_active_o),
  .ringing_common_mode_o(ringing_common_mode_o), .current_boost_o(current_boost_o), .irq_o(irq_o));

// ---- rortd_debounce.sv ----
// module: debounce filter for the trip comparator
`timescale 1ns/100ps
module rortd_debounce
  import rortd_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       sample_i,
  input  wire logic       in_i,
  input  wire logic [6:0] interval_i,
  output logic            out_o
);

  typedef struct packed {
    logic       out;
    logic [6:0] cnt;
  } rortd_deb_st_t;

  rortd_deb_st_t st;
  rortd_deb_st_t next_st;

  // ---------------------------------------------------------------------------
  // output flips only after the input disagrees for a full interval
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (sample_i) begin
      if (in_i == st.out) begin
        next_st.cnt = 7'h00;                                     // agreement restarts the wait
      end else if (({1'b0, st.cnt} + 8'h01) >= {1'b0, interval_i}) begin
        next_st.out = in_i;
        next_st.cnt = 7'h00;
      end else begin
        next_st.cnt = st.cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_o = st.out;

endmodule : rortd_debounce

// ---- rortd_line.sv ----
// partner: subscriber line model giving loop current and the ringing wave
`timescale 1ns/100ps
module rortd_line (
  input  wire logic        ref_clk_i,
  input  wire logic        off_hook_i,
  input  wire logic [15:0] amp_i,
  output logic [7:0]       sense_o = 8'h00,
  output logic [15:0]      wave_o = 16'h0000
);
  logic ph = 1'b0;
  // lsb ripple, so a detector without filtering would chatter
  always_ff @(posedge ref_clk_i) begin
    ph      <= ~ph;
    sense_o <= (off_hook_i ? 8'hf0 : 8'h04) ^ {7'h00, ph};
    wave_o  <= amp_i;
  end
endmodule : rortd_line

// ---- rortd_lpf.sv ----
// module: loop current low-pass filter and trip threshold comparator
`timescale 1ns/100ps
module rortd_lpf
  import rortd_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        sample_i,
  input  wire logic [7:0]  lcs_i,
  input  wire logic [12:0] coef_i,
  input  wire logic [5:0]  threshold_i,
  output logic             above_o
);

  typedef struct packed {
    logic [15:0] y;       // filtered current, 8.8 fixed point
    logic        above;
  } rortd_lpf_st_t;

  rortd_lpf_st_t st;
  rortd_lpf_st_t next_st;
  logic signed [16:0] diff;
  logic signed [30:0] prod;
  logic signed [17:0] sum;

  // ---------------------------------------------------------------------------
  // first order filter: y += (x - y) * coef / 2^13
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    diff    = $signed({1'b0, lcs_i, 8'h00}) - $signed({1'b0, st.y});
    prod    = diff * $signed({1'b0, coef_i});
    sum     = $signed({2'b00, st.y}) + prod[30:13];
    if (sample_i) begin
      next_st.y     = sum[15:0];
      next_st.above = st.y[15:8] > {2'b00, threshold_i};
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign above_o = st.above;

endmodule : rortd_lpf

// ---- rortd_pkg.sv ----
// package: constants, register map and carrier types of the ring offset / ring trip block
package rortd_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ             = 50_000_000;
  localparam int unsigned SAMPLE_RATE_HZ     = 1000;      // ringing / trip sample rate
  localparam int unsigned SAMPLE_TICK_CYCLES = CLK_HZ / SAMPLE_RATE_HZ;
  localparam int unsigned BOOST_TIME_MS      = 10;        // current limit boost length
  localparam logic [7:0]  BOOST_TICKS        = 8'(BOOST_TIME_MS * SAMPLE_RATE_HZ / 1000);

  // ---------------------------------------------------------------------------
  // direct register indices (byte address = 4 * index)
  // ---------------------------------------------------------------------------
  localparam logic [9:0] IDX_IRQ_PEND  = 10'h013;  // 19
  localparam logic [9:0] IDX_IRQ_EN    = 10'h016;  // 22
  localparam logic [9:0] IDX_IND_LO    = 10'h01c;  // 28
  localparam logic [9:0] IDX_IND_HI    = 10'h01d;  // 29
  localparam logic [9:0] IDX_IND_WADDR = 10'h01e;  // 30
  localparam logic [9:0] IDX_IND_RADDR = 10'h01f;  // 31
  localparam logic [9:0] IDX_RING_CTRL = 10'h022;  // 34
  localparam logic [9:0] IDX_ON_LO     = 10'h030;  // 48
  localparam logic [9:0] IDX_ON_HI     = 10'h031;  // 49
  localparam logic [9:0] IDX_OFF_LO    = 10'h032;  // 50
  localparam logic [9:0] IDX_OFF_HI    = 10'h033;  // 51
  localparam logic [9:0] IDX_LINEFEED  = 10'h040;  // 64
  localparam logic [9:0] IDX_STATUS    = 10'h044;  // 68
  localparam logic [9:0] IDX_DEBOUNCE  = 10'h046;  // 70
  localparam logic [9:0] IDX_HIGH_BATT = 10'h04a;  // 74
  localparam logic [9:0] IDX_LCS       = 10'h04f;  // 79
  localparam logic [9:0] IDX_BOOST     = 10'h06c;  // 108

  // indirect register numbers
  localparam logic [7:0] IND_OFFSET    = 8'h06;
  localparam logic [7:0] IND_THRESHOLD = 8'h10;
  localparam logic [7:0] IND_COEF      = 8'h17;
  localparam logic [7:0] IND_HEADROOM  = 8'h1b;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned POS_OFFSET_EN  = 1;   // ring control
  localparam int unsigned POS_ON_TMR_EN  = 2;
  localparam int unsigned POS_OFF_TMR_EN = 3;
  localparam int unsigned POS_BOOST_EN   = 7;
  localparam int unsigned POS_SHADOW     = 4;   // linefeed shadow at [6:4]

  // ---------------------------------------------------------------------------
  // types and reset values
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    LF_OPEN     = 3'h0,
    LF_ACTIVE   = 3'h1,
    LF_OHT      = 3'h2,
    LF_RINGING  = 3'h4
  } rortd_lf_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_ON   = 2'h1,
    PH_OFF  = 2'h2
  } rortd_phase_t;

  typedef struct packed {
    logic        offset_en;
    logic        on_en;
    logic        off_en;
    logic [15:0] on_time;
    logic [15:0] off_time;
    logic [2:0]  linefeed;
    logic [6:0]  debounce;
    logic [5:0]  high_batt;
    logic        boost_en;
    logic [15:0] offset;
    logic [5:0]  threshold;
    logic [12:0] coef;
    logic [3:0]  headroom;
    logic        irq_en;
  } rortd_cfg_t;

  localparam rortd_cfg_t CFG_RESET = '0;

endpackage : rortd_pkg

// ---- rortd_top.sv ----
// module: ringing offset, balanced common mode, cadence and ring trip detection with apb registers

`timescale 1ns/100ps
module rortd_top
  import rortd_pkg::*;
#(
  parameter logic [15:0] TICK_CYCLES = 16'(SAMPLE_TICK_CYCLES)
) (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [7:0]  loop_current_sense_i,
  input  wire logic [15:0] ring_wave_i,
  output logic [15:0]      ring_drive_o,
  output logic             ringing_active_o,
  output logic [5:0]       ringing_common_mode_o,
  output logic             current_boost_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    // programmed settings
    rortd_cfg_t   cfg;
    logic [7:0]   ind_lo;
    logic [7:0]   ind_hi;
    logic [7:0]   ind_addr;

    // irq and timing
    logic         irq_pend;
    logic [15:0]  tick_cnt;
    logic         tick;
    rortd_phase_t phase;
    logic [15:0]  cad_cnt;

    // boost, sense sync
    logic [7:0]   boost_cnt;
    logic         boost;
    logic [7:0]   lcs_s1;
    logic [7:0]   lcs_s2;
    logic         trip_q;

    // output flops
    logic [15:0]  ring_drive;
    logic [5:0]   cm;
    logic [31:0]  prdata;
    logic         pslverr;
  } rortd_st_t;

  rortd_st_t  st;
  rortd_st_t  next_st;

  // process glue
  logic       sample;
  logic       above;
  logic       trip_status;
  logic [2:0] shadow;
  logic [9:0] idx;
  logic       setup;
  logic       wr;
  logic       mapped;
  logic [31:0] rd_word;

  // ---------------------------------------------------------------------------
  // linefeed shadow: off phase of a ring shows on-hook transmission
  // ---------------------------------------------------------------------------
  always_comb begin
    if (st.cfg.linefeed != LF_RINGING) begin
      shadow = st.cfg.linefeed;
    end else if (st.phase == PH_OFF) begin
      shadow = LF_OHT;
    end else begin
      shadow = LF_RINGING;
    end
  end

  // detector runs on the sample tick only while the shadow says ringing
  assign sample = st.tick && (shadow == LF_RINGING);

  // ---------------------------------------------------------------------------
  // trip detector chain
  // ---------------------------------------------------------------------------
  // filter, compare, debounce
  rortd_lpf u_lpf (
    .ref_clk_i   (ref_clk_i),
    .resetn_i    (resetn_i),
    .sample_i    (sample),
    .lcs_i       (st.lcs_s2),
    .coef_i      (st.cfg.coef),
    .threshold_i (st.cfg.threshold),
    .above_o     (above)
  );

  rortd_debounce u_deb (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .sample_i   (sample),
    .in_i       (above),
    .interval_i (st.cfg.debounce),
    .out_o      (trip_status)
  );

  // ---------------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------------
  // setup reads, access writes
  assign idx   = paddr_i[11:2];
  assign setup = psel_i && !penable_i;
  assign wr    = psel_i && penable_i && pwrite_i && !st.pslverr;

  // read mux, also tells whether the index is mapped
  // unmapped: zero data and an error
  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (idx)
      IDX_IRQ_PEND:  rd_word[0] = st.irq_pend;
      IDX_IRQ_EN:    rd_word[0] = st.cfg.irq_en;
      IDX_IND_LO:    rd_word[7:0] = st.ind_lo;
      IDX_IND_HI:    rd_word[7:0] = st.ind_hi;
      IDX_IND_WADDR: rd_word[7:0] = st.ind_addr;
      IDX_IND_RADDR: rd_word[7:0] = st.ind_addr;
      IDX_RING_CTRL: begin
        rd_word[POS_OFFSET_EN]  = st.cfg.offset_en;
        rd_word[POS_ON_TMR_EN]  = st.cfg.on_en;
        rd_word[POS_OFF_TMR_EN] = st.cfg.off_en;
      end
      IDX_ON_LO:     rd_word[7:0] = st.cfg.on_time[7:0];
      IDX_ON_HI:     rd_word[7:0] = st.cfg.on_time[15:8];
      IDX_OFF_LO:    rd_word[7:0] = st.cfg.off_time[7:0];
      IDX_OFF_HI:    rd_word[7:0] = st.cfg.off_time[15:8];
      IDX_LINEFEED: begin
        rd_word[2:0] = st.cfg.linefeed;
        rd_word[POS_SHADOW +: 3] = shadow;
      end
      IDX_STATUS:    rd_word[0] = trip_status;
      IDX_DEBOUNCE:  rd_word[6:0] = st.cfg.debounce;
      IDX_HIGH_BATT: rd_word[5:0] = st.cfg.high_batt;
      IDX_LCS:       rd_word[7:0] = st.lcs_s2;
      IDX_BOOST:     rd_word[POS_BOOST_EN] = st.cfg.boost_en;
      default:       mapped = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st = st;

    // pin synchroniser for the loop current sense sample
    // bits may skew; filter smooths it
    next_st.lcs_s1 = loop_current_sense_i;
    next_st.lcs_s2 = st.lcs_s1;

    // 1 kHz sample tick
    // free running, not tied to ring start
    next_st.tick = 1'b0;
    if (st.tick_cnt >= TICK_CYCLES - 16'h0001) begin
      next_st.tick_cnt = 16'h0000;
      next_st.tick     = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 16'h0001;
    end

    // read data is captured in the setup phase so it comes from flops
    if (setup) begin
      next_st.prdata  = mapped ? rd_word : 32'h0000_0000;
      next_st.pslverr = !mapped;
    end

    // register writes take effect in the access phase
    if (wr) begin
      unique case (idx)
        IDX_IRQ_EN:    next_st.cfg.irq_en = pwdata_i[0];
        IDX_IND_LO:    next_st.ind_lo = pwdata_i[7:0];
        IDX_IND_HI:    next_st.ind_hi = pwdata_i[7:0];
        IDX_IND_WADDR: begin
          next_st.ind_addr = pwdata_i[7:0];
          unique case (pwdata_i[7:0])
            IND_OFFSET:    next_st.cfg.offset    = {st.ind_hi, st.ind_lo};
            IND_THRESHOLD: next_st.cfg.threshold = st.ind_lo[5:0];
            IND_COEF:      next_st.cfg.coef      = {st.ind_hi[4:0], st.ind_lo};
            IND_HEADROOM:  next_st.cfg.headroom  = st.ind_lo[3:0];
            default:       next_st.ind_addr = pwdata_i[7:0];     // unknown indirect: ignored
          endcase
        end
        IDX_IND_RADDR: begin
          next_st.ind_addr = pwdata_i[7:0];
          unique case (pwdata_i[7:0])
            IND_OFFSET:    {next_st.ind_hi, next_st.ind_lo} = st.cfg.offset;
            IND_THRESHOLD: {next_st.ind_hi, next_st.ind_lo} = {10'h000, st.cfg.threshold};
            IND_COEF:      {next_st.ind_hi, next_st.ind_lo} = {3'h0, st.cfg.coef};
            IND_HEADROOM:  {next_st.ind_hi, next_st.ind_lo} = {12'h000, st.cfg.headroom};
            default:       {next_st.ind_hi, next_st.ind_lo} = 16'h0000;
          endcase
        end
        IDX_RING_CTRL: begin
          next_st.cfg.offset_en = pwdata_i[POS_OFFSET_EN];
          next_st.cfg.on_en     = pwdata_i[POS_ON_TMR_EN];
          next_st.cfg.off_en    = pwdata_i[POS_OFF_TMR_EN];
        end
        IDX_ON_LO:     next_st.cfg.on_time[7:0]   = pwdata_i[7:0];
        IDX_ON_HI:     next_st.cfg.on_time[15:8]  = pwdata_i[7:0];
        IDX_OFF_LO:    next_st.cfg.off_time[7:0]  = pwdata_i[7:0];
        IDX_OFF_HI:    next_st.cfg.off_time[15:8] = pwdata_i[7:0];
        IDX_LINEFEED:  next_st.cfg.linefeed = pwdata_i[2:0];
        IDX_DEBOUNCE:  next_st.cfg.debounce = pwdata_i[6:0];
        IDX_HIGH_BATT: next_st.cfg.high_batt = pwdata_i[5:0];
        IDX_BOOST:     next_st.cfg.boost_en = pwdata_i[POS_BOOST_EN];
        default:       next_st.cfg = st.cfg;                     // read-only or pending: no store
      endcase
    end

    // cadence: on and off timers count sample ticks
    unique case (st.phase)
      PH_IDLE: begin
        if (st.cfg.linefeed == LF_RINGING) begin
          next_st.phase   = PH_ON;
          next_st.cad_cnt = 16'h0000;
          next_st.cm = (st.cfg.high_batt > {2'b00, st.cfg.headroom}) ?
                       st.cfg.high_batt - {2'b00, st.cfg.headroom} : 6'h00;
        end
      end

      // on timer
      PH_ON: begin
        if (st.tick && st.cfg.on_en) begin
          if (st.cad_cnt + 16'h0001 >= st.cfg.on_time) begin
            next_st.phase   = PH_OFF;
            next_st.cad_cnt = 16'h0000;
          end else begin
            next_st.cad_cnt = st.cad_cnt + 16'h0001;
          end
        end
      end

      // off needs both timers
      PH_OFF: begin
        if (st.tick && st.cfg.off_en && st.cfg.on_en) begin
          if (st.cad_cnt + 16'h0001 >= st.cfg.off_time) begin
            next_st.phase   = PH_ON;
            next_st.cad_cnt = 16'h0000;
          end else begin
            next_st.cad_cnt = st.cad_cnt + 16'h0001;
          end
        end
      end
      default: next_st.phase = PH_IDLE;
    endcase

    // leaving the ringing state ends the cadence at once
    // and releases the common mode
    if (st.cfg.linefeed != LF_RINGING && st.phase != PH_IDLE) begin
      next_st.phase   = PH_IDLE;
      next_st.cad_cnt = 16'h0000;
      next_st.cm      = 6'h00;
    end

    // current limit boost on the step from ringing into a dc feed state
    // load lasts one cycle
    if (st.cfg.linefeed != LF_RINGING && st.phase != PH_IDLE &&
        st.cfg.linefeed != LF_OPEN && st.cfg.boost_en) begin
      next_st.boost_cnt = BOOST_TICKS;
    end else if (st.tick && st.boost_cnt != 8'h00) begin
      next_st.boost_cnt = st.boost_cnt - 8'h01;
    end
    next_st.boost = next_st.boost_cnt != 8'h00;

    // ringing output: offset only when enabled and only in the on phase
    if (st.phase == PH_ON) begin
      next_st.ring_drive = st.cfg.offset_en ? ring_wave_i + st.cfg.offset : ring_wave_i;
    end else begin
      next_st.ring_drive = 16'h0000;
    end

    // sticky pending flag: a new trip wins over a same-cycle clear
    // starts low like the status
    next_st.trip_q = trip_status;
    if (wr && idx == IDX_IRQ_PEND && pwdata_i[0]) begin
      next_st.irq_pend = 1'b0;
    end
    if (trip_status && !st.trip_q) begin
      next_st.irq_pend = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st     <= '0;
      st.cfg <= CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign prdata_o              = st.prdata;
  assign pready_o              = 1'b1;                           // zero wait states
  assign pslverr_o             = psel_i && penable_i && st.pslverr;

  // line side
  assign ring_drive_o          = st.ring_drive;
  assign ringing_active_o      = st.phase == PH_ON;
  assign ringing_common_mode_o = st.cm;                          // 0.75 V per step
  assign current_boost_o       = st.boost;

  // interrupt
  assign irq_o                 = st.irq_pend && st.cfg.irq_en;

endmodule : rortd_top

// ---- rortd_top_bench.sv ----
// testbench: apb-driven checks of offset, cadence, trip and boost
`timescale 1ns/100ps
module rortd_top_bench;
  import rortd_pkg::*;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  localparam int T = 8;  // short tick keeps the run small
  logic ref_clk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, hook = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rdat;
  logic        pready_o, pslverr_o, rerr, ringing_active_o, current_boost_o, irq_o;
  logic [7:0]  sense, ind [4];
  logic [15:0] amp = 16'h0, wave, ring_drive_o, val [4], v;
  logic [5:0]  ringing_common_mode_o, hb;
  int          n_errors = 0, checks_done = 0, cyc = 0, k, i;

  rortd_top #(.TICK_CYCLES(16'(T))) dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .loop_current_sense_i(sense), .ring_wave_i(wave),
    .ring_drive_o(ring_drive_o), .ringing_active_o(ringing_active_o),
    .ringing_common_mode_o(ringing_common_mode_o), .current_boost_o(current_boost_o), .irq_o(irq_o));
  rortd_line line_u (.ref_clk_i(ref_clk_i), .off_hook_i(hook), .amp_i(amp), .sense_o(sense), .wave_o(wave));

  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // hang guard, well above the expected run of about a thousand cycles
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  // ---------------------------------------------------------------------------
  // tasks and expectations
  // ---------------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // one apb transfer, idle cycle in front so strobes never toggle twice
  task automatic xf(input logic w, input logic [9:0] ix, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= {ix, 2'b00}; pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0; penable_i <= 1'b0;
  endtask : xf
  task automatic iw(input logic [7:0] n, input logic [15:0] d);
    xf(1'b1, IDX_IND_LO, 32'(d[7:0]));
    xf(1'b1, IDX_IND_HI, 32'(d[15:8]));
    xf(1'b1, IDX_IND_WADDR, 32'(n));
  endtask : iw
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wt
  function automatic logic [15:0] im(input logic [7:0] n);
    return (n == IND_OFFSET) ? 16'hffff : (n == IND_THRESHOLD) ? 16'h003f : (n == IND_COEF) ? 16'h1fff : 16'h000f;
  endfunction : im
  function automatic logic [5:0] f_cm(input logic [5:0] b, input logic [5:0] h);
    return (b > h) ? b - h : 6'h00;
  endfunction : f_cm
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    ind = '{IND_OFFSET, IND_THRESHOLD, IND_COEF, IND_HEADROOM};
    void'($urandom(32'h9a4994c5));
    wt(12);
    resetn_i <= 1'b1;
    // reset values, read-only status, unmapped place
    xf(1'b1, IDX_STATUS, 32'h1);
    xf(1'b0, IDX_STATUS, 32'h0); chk(rdat, 32'h0);
    xf(1'b0, IDX_IRQ_PEND, 32'h0); chk(rdat, 32'h0);
    xf(1'b0, 10'h3ff, 32'h0); chk({rerr, rdat[30:0]}, 32'h80000000);
    $display("test registers done");
    // indirect set written in full, then read back
    for (i = 0; i < 4; i++) begin
      val[i] = 16'($urandom) | 16'h0020;
      iw(ind[i], val[i]);
    end
    for (i = 0; i < 4; i++) begin
      xf(1'b1, IDX_IND_RADDR, 32'(ind[i]));
      xf(1'b0, IDX_IND_LO, 32'h0); v[7:0] = rdat[7:0];
      xf(1'b0, IDX_IND_HI, 32'h0); chk(32'({rdat[7:0], v[7:0]}), 32'(val[i] & im(ind[i])));
    end
    $display("test indirect done");
    // ringing: common mode, shadow, offset on and off
    hb = 6'($urandom) | 6'h20;
    xf(1'b1, IDX_HIGH_BATT, 32'(hb));
    xf(1'b1, IDX_LINEFEED, 32'h4);
    wt(4);
    chk(32'(ringing_common_mode_o), 32'(f_cm(hb, 6'(val[3] & 16'h000f))));
    chk(32'(ringing_active_o), 32'h1);
    xf(1'b0, IDX_LINEFEED, 32'h0); chk(32'(rdat[6:4]), 32'h4);
    for (i = 0; i < 2; i++) begin
      amp <= 16'($urandom);
      xf(1'b1, IDX_RING_CTRL, 32'(i * 2));
      wt(3);
      chk(32'(ring_drive_o), 32'(16'(amp + (i == 1 ? val[0] : 16'h0000))));
    end
    $display("test offset done");
    // cadence: three ticks on, two off, both timers enabled
    xf(1'b1, IDX_ON_LO, 32'h3);
    xf(1'b1, IDX_OFF_LO, 32'h2);
    xf(1'b1, IDX_RING_CTRL, 32'hc);
    xf(1'b1, IDX_LINEFEED, 32'h1);
    xf(1'b1, IDX_LINEFEED, 32'h4);
    wt(2);
    for (k = 0; k < 200 && ringing_active_o !== 1'b0; k++) wt(1);
    chk(32'(k >= 2 * T - 2 && k <= 3 * T + 4), 32'h1);
    xf(1'b0, IDX_LINEFEED, 32'h0); chk(32'(rdat[6:4]), 32'h2);
    for (k = 0; k < 200 && ringing_active_o !== 1'b1; k++) wt(1);
    chk(32'(k <= 2 * T + 2), 32'h1);
    $display("test cadence done");
    // trip: ignored off ringing, then debounced, latched, masked, cleared
    xf(1'b1, IDX_RING_CTRL, 32'h0);
    xf(1'b1, IDX_LINEFEED, 32'h1);
    iw(IND_THRESHOLD, 16'h0020);
    iw(IND_COEF, 16'h1000);
    xf(1'b1, IDX_DEBOUNCE, 32'h3);
    xf(1'b1, IDX_IRQ_EN, 32'h1);
    hook <= 1'b1;
    wt(20 * T);
    xf(1'b0, IDX_STATUS, 32'h0); chk(32'(rdat[0]), 32'h0);
    xf(1'b1, IDX_LINEFEED, 32'h4);
    for (k = 0; k < 60 * T && irq_o !== 1'b1; k++) wt(1);
    chk(32'(k >= 3 * T), 32'h1);
    chk(32'(irq_o), 32'h1);
    xf(1'b0, IDX_STATUS, 32'h0); chk(32'(rdat[0]), 32'h1);
    hook <= 1'b0;
    wt(30 * T);
    xf(1'b0, IDX_STATUS, 32'h0); chk(32'(rdat[0]), 32'h0);
    xf(1'b0, IDX_IRQ_PEND, 32'h0); chk(32'(rdat[0]), 32'h1);
    xf(1'b1, IDX_IRQ_EN, 32'h0);
    wt(1);
    chk(32'(irq_o), 32'h0);
    xf(1'b1, IDX_IRQ_PEND, 32'h1);
    xf(1'b1, IDX_IRQ_EN, 32'h1);
    xf(1'b0, IDX_IRQ_PEND, 32'h0); chk(32'({rdat[0], irq_o}), 32'h0);
    $display("test trip done");
    // boost on the way from ringing to an active feed
    xf(1'b1, IDX_BOOST, 32'h80);
    xf(1'b1, IDX_LINEFEED, 32'h1);
    for (k = 0; k < 4 * T && current_boost_o !== 1'b1; k++) wt(1);
    chk(32'(current_boost_o), 32'h1);
    for (k = 0; k < 20 * T && current_boost_o !== 1'b0; k++) wt(1);
    chk(32'(k >= (int'(BOOST_TICKS) - 1) * T && k <= int'(BOOST_TICKS) * T + 2), 32'h1);
    chk(32'(ringing_common_mode_o), 32'h0);
    $display("test boost done");
    summarize();
  end
endmodule : rortd_top_bench
